// File: hdl/wdtw_defines.svh
// Constants for the windowed watchdog: register offsets, bit positions,
// reset values and divider figures.
// Assumes inclusion by bare name from every file that needs the numbers.
`ifndef WDTW_DEFINES_SVH
`define WDTW_DEFINES_SVH

`define WDTW_ADDR_W          4
`define WDTW_OFS_RESET_CTRL  4'h0
`define WDTW_OFS_CONFIG_ONE  4'h4

`define WDTW_BIT_IDLE        2
`define WDTW_BIT_SLEEP       3
`define WDTW_BIT_TIMEOUT     4
`define WDTW_BIT_SOFT_EN     5

`define WDTW_POST_LSB        0
`define WDTW_POST_MSB        3
`define WDTW_BIT_PRESCALE    4
`define WDTW_BIT_WINDOW_DISABLE      6
`define WDTW_BIT_HARD_EN     7

`define WDTW_CFG_POST_RST    4'hf
`define WDTW_CFG_PRE_RST     1'h1
`define WDTW_CFG_WINDOW_DISABLE_RST  1'h1
`define WDTW_CFG_HARD_RST    1'h0

`define WDTW_RC_FREQ_KHZ     31
`define WDTW_BASE_5BIT_MS    1
`define WDTW_BASE_7BIT_MS    4
`define WDTW_PRE_SHIFT_5BIT  5
`define WDTW_PRE_SHIFT_7BIT  7
`define WDTW_CNT_W           23
`define WDTW_QUARTER_SHIFT   2
`define WDTW_DATA_ZERO       32'h00000000

`endif

// File: hdl/wdtw_pkg.sv
// Types shared by the windowed watchdog files.
// Assumes the defines header is compiled alongside.
`include "wdtw_defines.svh"

package wdtw_pkg;

	typedef enum logic [1:0] {
		WDTW_RUN,
		WDTW_SLEEP,
		WDTW_IDLE
	} wdtw_power_e;

	typedef logic [`WDTW_CNT_W-1:0] wdtw_count_t;

endpackage : wdtw_pkg

// File: hdl/wdtw_sync.sv
// Two-stage synchroniser for one level from outside the system clock.
// Assumes the input is a slow level such as the RC oscillator output.
`timescale 1ns/100ps
`default_nettype none

module wdtw_sync (
	input  wire logic sys_clk_in,
	input  wire logic sys_rst_in,
	input  wire logic async_in,
	output var  logic sync_out
);

	logic stage_one;

	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			stage_one <= 1'b0;
			sync_out  <= 1'b0;
		end else begin
			stage_one <= async_in;
			sync_out  <= stage_one;
		end
	end

endmodule : wdtw_sync

`default_nettype wire

// File: hdl/wdtw_top.sv
// Windowed watchdog with prescaler, postscaler and an Avalon-MM register slave.
// Assumes the RC oscillator arrives as a pin far slower than the system clock.
`timescale 1ns/100ps
`default_nettype none
`include "wdtw_defines.svh"

module wdtw_top
	import wdtw_pkg::*;
(
	input  wire logic                   sys_clk_in,
	input  wire logic                   sys_rst_in,
	input  wire logic                   low_power_rc_osc_in,
	input  wire logic                   watchdog_clear_instr_in,
	input  wire logic                   power_save_instr_in,
	input  wire logic                   power_save_idle_in,
	input  wire logic                   wake_event_in,
	input  wire logic                   osc_switch_done_in,
	input  wire logic [`WDTW_ADDR_W-1:0] avs_address_in,
	input  wire logic                   avs_read_in,
	input  wire logic                   avs_write_in,
	input  wire logic [31:0]            avs_writedata_in,
	output var  logic [31:0]            avs_readdata_out,
	output logic                        avs_waitrequest_out,
	output var  logic                   low_power_rc_osc_en_out,
	output var  logic                   wdt_reset_out,
	output var  logic                   wake_out,
	output var  logic                   sleeping_out
);

	// Full period in RC edges: prescale divisor times the postscale ratio.
	function automatic wdtw_count_t period_len(input logic [3:0] post, input logic pre7);
		wdtw_count_t one;
		one = {{(`WDTW_CNT_W-1){1'b0}}, 1'b1};
		if (pre7) begin
			period_len = one << (`WDTW_PRE_SHIFT_7BIT + post);
		end else begin
			period_len = one << (`WDTW_PRE_SHIFT_5BIT + post);
		end
	endfunction : period_len

	logic        soft_enable_bit;
	logic        timeout_flag;
	logic        sleep_flag;
	logic        idle_flag;
	logic [3:0]  postscale_select;
	logic        prescale_select;
	logic        window_disable;
	logic        hard_enable_fuse;
	wdtw_power_e power_state;
	wdtw_count_t wdt_count;
	logic        rc_sync;
	logic        rc_prev;
	logic        rc_edge;
	logic        wdt_enabled;
	logic        windowed;
	logic        ack;
	logic        wr_take;
	logic        rst_ctrl_wr;
	logic        cfg_wr;
	logic        in_power_save;
	logic        at_terminal;
	logic        timeout;
	logic        window_open;
	logic        early_clear;
	logic        good_clear;
	logic        leave_power_save;
	logic        counter_zero;
	wdtw_count_t period;

	wdtw_sync u_rc_sync (
		.sys_clk_in (sys_clk_in),
		.sys_rst_in (sys_rst_in),
		.async_in   (low_power_rc_osc_in),
		.sync_out   (rc_sync)
	);

	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rc_prev <= 1'b0;
		end else begin
			rc_prev <= rc_sync;
		end
	end

	assign rc_edge = rc_sync & ~rc_prev;

	// Bus slave answers on the second edge of each request.
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack;
	assign wr_take             = avs_write_in & ack;
	assign rst_ctrl_wr         = wr_take & (avs_address_in == `WDTW_OFS_RESET_CTRL);
	assign cfg_wr              = wr_take & (avs_address_in == `WDTW_OFS_CONFIG_ONE);

	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ack <= 1'b0;
		end else begin
			ack <= (avs_read_in | avs_write_in) & ~ack;
		end
	end

	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			avs_readdata_out <= `WDTW_DATA_ZERO;
		end else if (avs_read_in & ~ack) begin
			avs_readdata_out <= `WDTW_DATA_ZERO;
			if (avs_address_in == `WDTW_OFS_RESET_CTRL) begin
				avs_readdata_out[`WDTW_BIT_IDLE]    <= idle_flag;
				avs_readdata_out[`WDTW_BIT_SLEEP]   <= sleep_flag;
				avs_readdata_out[`WDTW_BIT_TIMEOUT] <= timeout_flag;
				avs_readdata_out[`WDTW_BIT_SOFT_EN] <= soft_enable_bit;
			end else if (avs_address_in == `WDTW_OFS_CONFIG_ONE) begin
				avs_readdata_out[`WDTW_POST_MSB:`WDTW_POST_LSB] <= postscale_select;
				avs_readdata_out[`WDTW_BIT_PRESCALE]            <= prescale_select;
				avs_readdata_out[`WDTW_BIT_WINDOW_DISABLE]              <= window_disable;
				avs_readdata_out[`WDTW_BIT_HARD_EN]             <= hard_enable_fuse;
			end
		end
	end

	// Configuration word stands in for the fuses; it is loaded by software.
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			postscale_select <= `WDTW_CFG_POST_RST;
			prescale_select  <= `WDTW_CFG_PRE_RST;
			window_disable   <= `WDTW_CFG_WINDOW_DISABLE_RST;
			hard_enable_fuse <= `WDTW_CFG_HARD_RST;
		end else if (cfg_wr) begin
			postscale_select <= avs_writedata_in[`WDTW_POST_MSB:`WDTW_POST_LSB];
			prescale_select  <= avs_writedata_in[`WDTW_BIT_PRESCALE];
			window_disable   <= avs_writedata_in[`WDTW_BIT_WINDOW_DISABLE];
			hard_enable_fuse <= avs_writedata_in[`WDTW_BIT_HARD_EN];
		end
	end

	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			soft_enable_bit <= 1'b0;
		end else if (rst_ctrl_wr) begin
			soft_enable_bit <= avs_writedata_in[`WDTW_BIT_SOFT_EN];
		end
	end

	assign wdt_enabled = hard_enable_fuse | soft_enable_bit;
	assign windowed    = ~window_disable;

	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			low_power_rc_osc_en_out <= 1'b0;
		end else begin
			low_power_rc_osc_en_out <= wdt_enabled;
		end
	end

	// Period is 32 or 128 RC edges times the postscale ratio, 1 ms or 4 ms at 1:1.
	assign period      = period_len(postscale_select, prescale_select);
	assign at_terminal = (wdt_count == period - 1'b1);
	assign timeout     = wdt_enabled & rc_edge & at_terminal;
	// Final quarter starts at three quarters of the period.
	assign window_open = wdt_count >= (period - (period >> `WDTW_QUARTER_SHIFT));
	assign in_power_save = (power_state != WDTW_RUN);

	assign early_clear = wdt_enabled & windowed & watchdog_clear_instr_in
		& ~in_power_save & ~window_open;
	assign good_clear  = watchdog_clear_instr_in & ~in_power_save
		& (~windowed | window_open);

	assign leave_power_save = in_power_save & (wake_event_in | timeout);

	assign counter_zero = osc_switch_done_in | power_save_instr_in | leave_power_save
		| good_clear | early_clear | timeout | ~wdt_enabled;

	// Prescaler and postscaler are one merged counter, so one clear zeroes both.
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wdt_count <= '0;
		end else if (counter_zero) begin
			wdt_count <= '0;
		end else if (rc_edge) begin
			wdt_count <= wdt_count + 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			power_state <= WDTW_RUN;
		end else begin
			unique case (power_state)
				WDTW_RUN: begin
					if (power_save_instr_in) begin
						power_state <= power_save_idle_in ? WDTW_IDLE : WDTW_SLEEP;
					end
				end
				WDTW_SLEEP, WDTW_IDLE: begin
					if (leave_power_save) begin
						power_state <= WDTW_RUN;
					end
				end
				default: begin
					power_state <= WDTW_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wake_out      <= 1'b0;
			wdt_reset_out <= 1'b0;
		end else begin
			wake_out      <= timeout & in_power_save;
			wdt_reset_out <= (timeout & ~in_power_save) | early_clear;
		end
	end

	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sleeping_out <= 1'b0;
		end else begin
			sleeping_out <= in_power_save & ~leave_power_save;
		end
	end

	// Hardware set wins over a software clear in the same cycle.
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			timeout_flag <= 1'b0;
		end else if (timeout | early_clear) begin
			timeout_flag <= 1'b1;
		end else if (rst_ctrl_wr & ~avs_writedata_in[`WDTW_BIT_TIMEOUT]) begin
			timeout_flag <= 1'b0;
		end
	end

	// The status bits remain set after a wake so software can see the cause.
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sleep_flag <= 1'b0;
			idle_flag  <= 1'b0;
		end else begin
			if (power_save_instr_in & ~in_power_save & ~power_save_idle_in) begin
				sleep_flag <= 1'b1;
			end else if (rst_ctrl_wr & ~avs_writedata_in[`WDTW_BIT_SLEEP]) begin
				sleep_flag <= 1'b0;
			end
			if (power_save_instr_in & ~in_power_save & power_save_idle_in) begin
				idle_flag <= 1'b1;
			end else if (rst_ctrl_wr & ~avs_writedata_in[`WDTW_BIT_IDLE]) begin
				idle_flag <= 1'b0;
			end
		end
	end

endmodule : wdtw_top

`default_nettype wire

// File: testbench/wdtw_top_asserts.sv
// Port checker for the windowed watchdog.
// Assumes a bind to wdtw_top, one clock and an active high reset.
`timescale 1ns/100ps
`default_nettype none
module wdtw_top_asserts (
	input wire logic	sys_clk_in,
	input wire logic	sys_rst_in,
	input wire logic	low_power_rc_osc_in,
	input wire logic	watchdog_clear_instr_in,
	input wire logic	power_save_instr_in,
	input wire logic	power_save_idle_in,
	input wire logic	wake_event_in,
	input wire logic	osc_switch_done_in,
	input wire logic [3:0]	avs_address_in,
	input wire logic	avs_read_in,
	input wire logic	avs_write_in,
	input wire logic [31:0]	avs_writedata_in,
	input wire logic [31:0]	avs_readdata_out,
	input wire logic	avs_waitrequest_out,
	input wire logic	low_power_rc_osc_en_out,
	input wire logic	wdt_reset_out,
	input wire logic	wake_out,
	input wire logic	sleeping_out
);
	default clocking @(posedge sys_clk_in);
	endclocking
	default disable iff (sys_rst_in);
	property p_wait; $rose(avs_read_in | avs_write_in) |->
		avs_waitrequest_out ##1 !avs_waitrequest_out; endproperty
	a_wait: assert property (p_wait) else $error("bus wait");
	property p_unmap; avs_read_in && avs_waitrequest_out && avs_address_in != 4'h0 &&
		avs_address_in != 4'h4 |=> avs_readdata_out == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_rc_en; wdt_reset_out || wake_out |-> low_power_rc_osc_en_out; endproperty
	a_rc_en: assert property (p_rc_en) else $error("rc enable");
	property p_rst_pulse; wdt_reset_out |=> !wdt_reset_out; endproperty
	a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse");
	property p_wake; wake_out |-> !wdt_reset_out ##1 !wake_out && !sleeping_out; endproperty
	a_wake: assert property (p_wake) else $error("wake pulse");
	property p_sleep; power_save_instr_in && !sleeping_out |-> ##2 sleeping_out; endproperty
	a_sleep: assert property (p_sleep) else $error("sleep entry");
	property p_exit; wake_event_in && sleeping_out |=> !sleeping_out; endproperty
	a_exit: assert property (p_exit) else $error("sleep exit");
	// Counters restart on these events, so no time-out can follow within eight cycles.
	property p_ps_zero; power_save_instr_in |=> (!wake_out && !wdt_reset_out) [*8]; endproperty
	a_ps_zero: assert property (p_ps_zero) else $error("power save restart");
	property p_osc_zero; osc_switch_done_in |=> !wdt_reset_out [*8]; endproperty
	a_osc_zero: assert property (p_osc_zero) else $error("switch restart");
	property p_clr_sleep; watchdog_clear_instr_in && sleeping_out |=> !wdt_reset_out; endproperty
	a_clr_sleep: assert property (p_clr_sleep) else $error("clear in sleep");
	c_reset: cover property (wdt_reset_out);
	c_wake: cover property (wake_out);
	c_unmap: cover property (avs_read_in && !avs_waitrequest_out && avs_address_in == 4'h8);
endmodule : wdtw_top_asserts
`default_nettype wire

// File: testbench/wdtw_top_test.sv
// Self-checking bench for the windowed watchdog.
// Assumes the design files and the port checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module wdtw_top_test import wdtw_pkg::*;;
	typedef struct {logic [3:0] a; logic [31:0] d; logic [31:0] e;} wdtw_row_s;
	wdtw_row_s	rows [4] = '{'{4'h4, 32'hffffffff, 32'hdf}, '{4'h8, 32'hffffffff, 32'h0},
		'{4'h0, 32'h20, 32'h20}, '{4'h4, 32'h40, 32'h40}};
	logic [31:0]	cfg [3] = '{32'h40, 32'h41, 32'h50};
	int	edg [3] = '{32, 64, 128};
	logic	clk = 1'b0;
	logic	rst = 1'b1;
	logic	rc = 1'b0;
	logic	idle = 1'b0;
	logic	rd = 1'b0;
	logic	wr = 1'b0;
	logic [1:0]	rcd = 2'h0;
	logic [3:0]	ev = 4'h0;
	logic [3:0]	adr = 4'h0;
	logic [31:0]	wd = 32'h0;
	logic [31:0]	q;
	logic [31:0]	rdq;
	logic	wt, en, wrst, wk, slp;
	int	err_total = 0;
	int	checks_done = 0;
	wdtw_top dut (
		.sys_clk_in(clk), .sys_rst_in(rst), .low_power_rc_osc_in(rc),
		.watchdog_clear_instr_in(ev[0]), .osc_switch_done_in(ev[1]),
		.power_save_instr_in(ev[2]), .wake_event_in(ev[3]), .power_save_idle_in(idle),
		.avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
		.avs_readdata_out(rdq), .avs_waitrequest_out(wt), .low_power_rc_osc_en_out(en),
		.wdt_reset_out(wrst), .wake_out(wk), .sleeping_out(slp));
	always #12.5 clk = ~clk;
	// The pin toggles every four cycles, so one counted edge arrives every eight.
	always @(posedge clk) begin
		rcd <= rcd + 2'h1;
		if (rcd == 2'h3) rc <= ~rc;
	end
	task finish_test;
		if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : finish_test
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task chk_rng(input string nm, input int lo, input int hi, input int g);
		checks_done++;
		if (g < lo || g > hi) begin
			err_total++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask : chk_rng
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		wr <= w;
		rd <= ~w;
		adr <= a;
		wd <= d;
		// Waitrequest is looked at mid-cycle, where it has settled.
		@(negedge clk);
		while (wt !== 1'b0 && n < 20) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		q = rdq;
		wr <= 1'b0;
		rd <= 1'b0;
		chk_rng("bus answer cycles", 1, 19, n);
	endtask : bus
	task rdchk(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk("register readback", e, q);
	endtask : rdchk
	task pulse(input int k);
		@(posedge clk);
		ev <= 4'h1 << k;
		@(posedge clk);
		ev <= 4'h0;
	endtask : pulse
	// Phase of the oscillator against the pulse is unknown, hence the slack.
	task run_to(input int k, input int n_edges, input logic wake);
		int n;
		n = 0;
		pulse(k);
		@(negedge clk);
		while ((wake ? wk : wrst) !== 1'b1 && n < n_edges * 8 + 64) begin
			@(negedge clk);
			n++;
		end
		chk_rng("timeout cycles", n_edges * 8 - 16, n_edges * 8 + 16, n);
	endtask : run_to
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rdchk(4'h0, 32'h0);
		rdchk(4'h4, 32'h5f);
		foreach (rows[i]) begin
			bus(1'b1, rows[i].a, rows[i].d);
			rdchk(rows[i].a, rows[i].e);
		end
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, 4'h4, cfg[i]);
			run_to(0, edg[i], 1'b0);
			rdchk(4'h0, 32'h30);
			bus(1'b1, 4'h0, 32'h30);
			rdchk(4'h0, 32'h30);
			bus(1'b1, 4'h0, 32'h20);
			rdchk(4'h0, 32'h20);
		end
		bus(1'b1, 4'h4, 32'h40);
		for (int i = 0; i < 2; i++) begin
			idle <= i[0];
			pulse(2);
			run_to(0, 32, 1'b1);
			rdchk(4'h0, i[0] ? 32'h34 : 32'h38);
			bus(1'b1, 4'h0, 32'h20);
		end
		pulse(2);
		pulse(3);
		@(posedge clk);
		chk("sleeping", 32'h0, {31'h0, slp});
		repeat (120) @(posedge clk);
		run_to(1, 32, 1'b0);
		bus(1'b1, 4'h4, 32'h0);
		run_to(0, 0, 1'b0);
		repeat (216) @(posedge clk);
		run_to(0, 32, 1'b0);
		bus(1'b1, 4'h4, 32'h40);
		bus(1'b1, 4'h0, 32'h0);
		repeat (400) @(posedge clk);
		rdchk(4'h0, 32'h0);
		chk("rc enable", 32'h0, {31'h0, en});
		bus(1'b1, 4'h4, 32'hc0);
		repeat (3) @(posedge clk);
		chk("rc enable", 32'h1, {31'h0, en});
		run_to(0, 32, 1'b0);
		bus(1'b1, 4'h0, 32'h20);
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		rdchk(4'h0, 32'h0);
		rdchk(4'h4, 32'h5f);
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		finish_test();
	end
endmodule : wdtw_top_test
bind wdtw_top wdtw_top_asserts chk_u (.*);
`default_nettype wire
